// ==== logic/motion_interrupt_status.sv ====
`timescale 1ns/1ps
module motion_interrupt_status (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Register access port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Configuration from other registers
  input  wire logic [7:0] int_enable_i,
  input  wire logic [7:0] motion_ctrl_i,
  input  wire logic       individual_clear_select_i,
  input  wire logic       wake_mode_i,
  // Event sources, one-cycle pulses
  input  wire logic       tilt_event_i,
  input  wire logic       flip_event_i,
  input  wire logic       any_motion_event_i,
  input  wire logic       shake_event_i,
  input  wire logic       tilt35_event_i,
  input  wire logic       sample_event_i,
  // Queue interrupt flags
  input  wire logic       queue_full_flag_i,
  input  wire logic       queue_threshold_flag_i,
  input  wire logic       queue_empty_flag_i,
  // Pending state
  output logic      [7:0] pending_interrupt_status_o
);

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [7:0] RST_VAL = motion_irq_pkg::PENDING_RESET;

  // ****************************************
  // Helper functions
  // ****************************************
  // Strobe aimed at the pending register
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr);
    return strobe & (addr == motion_irq_pkg::PENDING_ADDR);
  endfunction

  // Bits released by one register write
  function automatic logic [7:0] write_clear(input logic       hit,
                                             input logic       by_mask,
                                             input logic [7:0] mask);
    logic [7:0] bits;
    bits = 8'h00;
    if (hit && by_mask) begin
      bits = mask & motion_irq_pkg::PENDING_MASK;
    end else if (hit) begin
      bits = motion_irq_pkg::PENDING_MASK;
    end
    return bits;
  endfunction

  // Set wins over a clear in the same cycle
  function automatic logic bit_next(input logic cur,
                                    input logic set,
                                    input logic clr);
    return set | (cur & ~clr);
  endfunction

  // ****************************************
  // Signals
  // ****************************************
  logic [7:0] raw_event;
  logic [7:0] set_req;
  logic [7:0] clear_mask;
  logic [7:0] pending_view;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       queue_any;
  logic       hit_wr;
  logic       hit_rd;
  logic       tilt_pending_r;
  logic       tilt_pending_nxt;
  logic       flip_pending_r;
  logic       flip_pending_nxt;
  logic       any_motion_pending_r;
  logic       any_motion_pending_nxt;
  logic       shake_pending_r;
  logic       shake_pending_nxt;
  logic       tilt35_pending_r;
  logic       tilt35_pending_nxt;
  logic       queue_pending_r;
  logic       queue_pending_nxt;
  logic       sample_pending_r;
  logic       sample_pending_nxt;

  // ****************************************
  // Event gathering
  // ****************************************
  assign queue_any = queue_full_flag_i | queue_threshold_flag_i |
                     queue_empty_flag_i;

  assign raw_event = {sample_event_i, 1'b0, queue_any, tilt35_event_i,
                      shake_event_i, any_motion_event_i, flip_event_i,
                      tilt_event_i};

  pending_gate u_gate (
    .int_enable_i  (int_enable_i),
    .motion_ctrl_i (motion_ctrl_i),
    .wake_mode_i   (wake_mode_i),
    .event_i       (raw_event),
    .set_o         (set_req)
  );

  // ****************************************
  // Register access
  // ****************************************
  assign hit_wr     = addr_hit(reg_wr_i, reg_addr_i);
  assign hit_rd     = addr_hit(reg_rd_i, reg_addr_i);
  assign clear_mask = write_clear(hit_wr, individual_clear_select_i,
                                  reg_wdata_i);

  // ****************************************
  // Next pending state per source
  // ****************************************
  assign tilt_pending_nxt =
    bit_next(tilt_pending_r, set_req[motion_irq_pkg::TILT_BIT],
             clear_mask[motion_irq_pkg::TILT_BIT]);

  assign flip_pending_nxt =
    bit_next(flip_pending_r, set_req[motion_irq_pkg::FLIP_BIT],
             clear_mask[motion_irq_pkg::FLIP_BIT]);

  assign any_motion_pending_nxt =
    bit_next(any_motion_pending_r, set_req[motion_irq_pkg::ANYM_BIT],
             clear_mask[motion_irq_pkg::ANYM_BIT]);

  assign shake_pending_nxt =
    bit_next(shake_pending_r, set_req[motion_irq_pkg::SHAKE_BIT],
             clear_mask[motion_irq_pkg::SHAKE_BIT]);

  assign tilt35_pending_nxt =
    bit_next(tilt35_pending_r, set_req[motion_irq_pkg::TILT35_BIT],
             clear_mask[motion_irq_pkg::TILT35_BIT]);

  assign queue_pending_nxt =
    bit_next(queue_pending_r, set_req[motion_irq_pkg::QUEUE_BIT],
             clear_mask[motion_irq_pkg::QUEUE_BIT]);

  assign sample_pending_nxt =
    bit_next(sample_pending_r, set_req[motion_irq_pkg::SAMPLE_BIT],
             clear_mask[motion_irq_pkg::SAMPLE_BIT]);

  // ****************************************
  // Read path
  // ****************************************
  assign pending_view = {sample_pending_r, 1'b0, queue_pending_r,
                         tilt35_pending_r, shake_pending_r,
                         any_motion_pending_r, flip_pending_r,
                         tilt_pending_r};

  // Reading leaves the pending bits alone
  assign rdata_nxt = hit_rd ? pending_view : 8'h00;

  // ****************************************
  // State
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tilt_pending_r <= RST_VAL[motion_irq_pkg::TILT_BIT];
    end else begin
      tilt_pending_r <= tilt_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flip_pending_r <= RST_VAL[motion_irq_pkg::FLIP_BIT];
    end else begin
      flip_pending_r <= flip_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      any_motion_pending_r <= RST_VAL[motion_irq_pkg::ANYM_BIT];
    end else begin
      any_motion_pending_r <= any_motion_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shake_pending_r <= RST_VAL[motion_irq_pkg::SHAKE_BIT];
    end else begin
      shake_pending_r <= shake_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tilt35_pending_r <= RST_VAL[motion_irq_pkg::TILT35_BIT];
    end else begin
      tilt35_pending_r <= tilt35_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      queue_pending_r <= RST_VAL[motion_irq_pkg::QUEUE_BIT];
    end else begin
      queue_pending_r <= queue_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_pending_r <= RST_VAL[motion_irq_pkg::SAMPLE_BIT];
    end else begin
      sample_pending_r <= sample_pending_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= RST_VAL;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o                = rdata_r;
  assign pending_interrupt_status_o = pending_view;

endmodule

// ==== shared/motion_irq_pkg.sv ====
package motion_irq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PENDING_ADDR   = 8'h14;
  localparam logic [7:0] PENDING_RESET  = 8'h00;

  // ****************************************
  // Pending and enable bit positions
  // ****************************************
  localparam int TILT_BIT     = 0;
  localparam int FLIP_BIT     = 1;
  localparam int ANYM_BIT     = 2;
  localparam int SHAKE_BIT    = 3;
  localparam int TILT35_BIT   = 4;
  localparam int QUEUE_BIT    = 5;
  localparam int RESV_BIT     = 6;
  localparam int SAMPLE_BIT   = 7;

  // ****************************************
  // Motion control feature bits
  // ****************************************
  localparam int MC_TILT_FLIP = 0;
  localparam int MC_ANYM      = 2;
  localparam int MC_SHAKE     = 3;
  localparam int MC_TILT35    = 4;

  // Writable bits of the pending register
  localparam logic [7:0] PENDING_MASK = 8'hBF;

endpackage

// ==== logic/pending_gate.sv ====
`timescale 1ns/1ps
module pending_gate (
  // Enables
  input  wire logic [7:0] int_enable_i,
  input  wire logic [7:0] motion_ctrl_i,
  input  wire logic       wake_mode_i,
  // Raw events
  input  wire logic [7:0] event_i,
  // Qualified set requests
  output logic      [7:0] set_o
);

  // ****************************************
  // Per-source qualification
  // ****************************************
  wire anym_on = motion_ctrl_i[motion_irq_pkg::MC_ANYM];
  wire [7:0] allow;

  assign allow[motion_irq_pkg::TILT_BIT] =
    int_enable_i[motion_irq_pkg::TILT_BIT];
  assign allow[motion_irq_pkg::FLIP_BIT] =
    int_enable_i[motion_irq_pkg::FLIP_BIT] &
    motion_ctrl_i[motion_irq_pkg::MC_TILT_FLIP];
  assign allow[motion_irq_pkg::ANYM_BIT] =
    int_enable_i[motion_irq_pkg::ANYM_BIT] & anym_on;
  assign allow[motion_irq_pkg::SHAKE_BIT] =
    int_enable_i[motion_irq_pkg::SHAKE_BIT] & anym_on &
    motion_ctrl_i[motion_irq_pkg::MC_SHAKE];
  assign allow[motion_irq_pkg::TILT35_BIT] =
    int_enable_i[motion_irq_pkg::TILT35_BIT] & anym_on &
    motion_ctrl_i[motion_irq_pkg::MC_TILT35];
  assign allow[motion_irq_pkg::QUEUE_BIT] =
    int_enable_i[motion_irq_pkg::QUEUE_BIT];
  assign allow[motion_irq_pkg::RESV_BIT] = 1'b0;
  assign allow[motion_irq_pkg::SAMPLE_BIT] =
    int_enable_i[motion_irq_pkg::SAMPLE_BIT] & wake_mode_i;

  assign set_o = event_i & allow;

endmodule

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] data_o
);
  initial begin
    {wr_o, rd_o, addr_o, data_o} = 18'h00000;
  end
  // One strobe cycle, then strobes released low and address and data driven to inverse values
  task automatic access(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    {wr_o, rd_o, addr_o, data_o} <= {w, !w, a, d};
    @(posedge clk_i);
    {wr_o, rd_o, addr_o, data_o} <= {2'b00, ~a, ~d};
  endtask
endmodule

// ==== sim/irq_status_sva.sv ====
`timescale 1ns/1ps
module irq_status_sva (
  input wire logic       core_clk_i, rst_i, reg_wr_i, reg_rd_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire logic [7:0] int_enable_i, motion_ctrl_i,
  input wire logic       individual_clear_select_i, wake_mode_i,
  input wire logic       tilt_event_i, flip_event_i, any_motion_event_i,
  input wire logic       shake_event_i, tilt35_event_i, sample_event_i,
  input wire logic       queue_full_flag_i, queue_threshold_flag_i,
  input wire logic       queue_empty_flag_i,
  input wire logic [7:0] pending_interrupt_status_o
);
  wire [7:0] p = pending_interrupt_status_o;
  wire [7:0] e = int_enable_i;
  wire [7:0] c = motion_ctrl_i;
  wire       hit = reg_addr_i == 8'h14;
  wire       calm = e == 8'h00;
  wire [7:0] g = {e[7] & wake_mode_i & sample_event_i, 1'b0,
    e[5] & (queue_full_flag_i | queue_threshold_flag_i | queue_empty_flag_i),
    e[4] & c[4] & c[2] & tilt35_event_i, e[3] & c[3] & c[2] & shake_event_i,
    e[2] & c[2] & any_motion_event_i, e[1] & c[0] & flip_event_i,
    e[0] & tilt_event_i};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_set_gated: assert property (
    (p & ~$past(p) & ~$past(g)) == 8'h00) else $error("ungated set");
  a_set_taken: assert property (
    |g |=> (p & $past(g)) == $past(g)) else $error("set lost");
  a_hold_state: assert property (
    calm && !reg_wr_i |=> p == $past(p)) else $error("pending moved");
  a_clear_all: assert property (
    reg_wr_i && hit && !individual_clear_select_i && calm |=> p == 8'h00)
    else $error("group clear");
  a_indiv_clear: assert property (
    reg_wr_i && hit && individual_clear_select_i && calm
    |=> p == ($past(p) & ~$past(reg_wdata_i))) else $error("mask clear");
  a_read_data: assert property (
    reg_rd_i && !reg_wr_i && calm
    |=> reg_rdata_o == ($past(hit) ? p : 8'h00)) else $error("read data");
  a_resv_zero: assert property (
    p[6] == 1'b0 && reg_rdata_o[6] == 1'b0) else $error("reserved bit");
  a_reset_zero: assert property (
    $fell(rst_i) |-> p == 8'h00) else $error("reset value");
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  en = 8'h00, mc = 8'h00, m, k, rdata, pend, addr, wdata;
  logic [15:0] q[$], n;
  logic [5:0]  ev = 6'h00;
  logic [2:0]  qf = 3'h0;
  logic        ind = 1'b0, wake = 1'b0, wr, rd, seen = 1'b0;
  logic [31:0] r = 32'h913D8D46;
  int          failures = 0, total_checks = 0;
  host_model u_host (.clk_i(core_clk_i), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .data_o(wdata));
  motion_interrupt_status u_dut (.core_clk_i, .rst_i, .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .int_enable_i(en), .motion_ctrl_i(mc),
    .individual_clear_select_i(ind), .wake_mode_i(wake),
    .tilt_event_i(ev[0]), .flip_event_i(ev[1]), .any_motion_event_i(ev[2]),
    .shake_event_i(ev[3]), .tilt35_event_i(ev[4]), .sample_event_i(ev[5]),
    .queue_full_flag_i(qf[0]), .queue_threshold_flag_i(qf[1]),
    .queue_empty_flag_i(qf[2]), .pending_interrupt_status_o(pend));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_exp(input logic [7:0] a, exp, pexp);
    q.push_back({pexp, exp});
    u_host.access(1'b0, a, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    if (seen) begin
      n = q.pop_front();
      chk("reg_rdata_o", rdata, n[7:0]);
      chk("pending_interrupt_status_o", pend, n[15:8]);
    end
    seen <= rd;
  end
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_exp(8'h14, 8'h00, 8'h00);
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      @(posedge core_clk_i);
      {en, mc, ev, qf, wake} <= r[25:0];
      @(posedge core_clk_i);
      {en, ev, qf} <= 17'h00000;
      m = {en[7] & wake & ev[5], 1'b0, en[5] & |qf,
        en[4] & mc[4] & mc[2] & ev[4], en[3] & mc[3] & mc[2] & ev[3],
        en[2] & mc[2] & ev[2], en[1] & mc[0] & ev[1], en[0] & ev[0]};
      rd_exp(8'h14, m, m);
      ind <= r[27];
      k = r[27] ? m & ~r[31:24] : 8'h00;
      u_host.access(1'b1, 8'h14, r[31:24]);
      if (r[27]) rd_exp(8'h14, k, k);
      rd_exp(r[7:0] == 8'h14 ? 8'h13 : r[7:0], 8'h00, k);
      ind <= 1'b0;
      u_host.access(1'b1, 8'h14, r[15:8]);
      rd_exp(8'h14, 8'h00, 8'h00);
    end
    // Event and group clear in one cycle: the event stays
    en <= 8'h01;
    ev <= 6'h01;
    u_host.access(1'b1, 8'h14, 8'h00);
    {en, ev} <= 14'h0000;
    rd_exp(8'h14, 8'h01, 8'h01);
    u_host.access(1'b1, 8'h14, 8'h00);
    rd_exp(8'h14, 8'h00, 8'h00);
    repeat (3) @(posedge core_clk_i);
    if (q.size() != 0) begin
      failures++;
      $display("Error queue expected 0 seen %0d", q.size());
    end
    report_and_stop;
  end
endmodule
bind motion_interrupt_status irq_status_sva u_sva (.*);
